/* File: verilog/t1rc_pkg.sv */
`default_nettype none
package t1rc_pkg;
  // Host port register addresses and reset value
  localparam logic [7:0] T1RC_LRL_ADDR = 8'h0a;
  localparam logic [7:0] T1RC_RCM_ADDR = 8'h1e;
  localparam logic [7:0] T1RC_REG_RESET = 8'h00;
  // Field positions
  localparam int T1RC_CRC_JP_BIT = 7;
  localparam int T1RC_CHAN_MSB = 4;
  localparam int T1RC_CHAN_LSB = 0;
  localparam int T1RC_LINE_IF_RESET_BIT_BIT = 7;
  localparam int T1RC_RLB_BIT = 6;
  localparam int T1RC_CHAN_W = T1RC_CHAN_MSB - T1RC_CHAN_LSB + 1;
  // Timing
  localparam int T1RC_CLK_PERIOD_NS = 10;
  localparam int T1RC_LINE_IF_RESET_BIT_PULSE_NS = 1000;
  localparam int T1RC_LINE_IF_RESET_BIT_CYCLES =
    (T1RC_LINE_IF_RESET_BIT_PULSE_NS + T1RC_CLK_PERIOD_NS - 1) / T1RC_CLK_PERIOD_NS;
  localparam int T1RC_LINE_IF_RESET_BIT_CW = $clog2(T1RC_LINE_IF_RESET_BIT_CYCLES + 1);
  // Channel monitor stream
  localparam int T1RC_BYTE_W = 8;
  localparam int T1RC_MON_WIDTH = T1RC_BYTE_W + T1RC_CHAN_W;
  localparam int T1RC_FIFO_DEPTH = 16;

  typedef enum logic [0:0] {
    T1RC_RST_IDLE = 1'b0,
    T1RC_RST_PULSE = 1'b1
  } t1rc_rst_state_t;

  function automatic logic t1rc_addr_hit(input logic [7:0] addr,
                                         input logic [7:0] target);
    return addr == target;
  endfunction
endpackage
`default_nettype wire

/* File: verilog/t1rc_stream_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface t1rc_stream_if #(parameter int WIDTH = 8) ();
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface // t1rc_stream_if
`default_nettype wire

/* File: verilog/t1rc_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
module t1rc_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic reset_in,
  t1rc_stream_if.snk wr_if,
  t1rc_stream_if.src rd_if
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [CW-1:0] count_q, count_d;
  logic [WIDTH-1:0] out_q, out_d;
  logic out_vld_q, out_vld_d;
  logic push, pop;

  // Read data always leave from a register
  always_comb begin
    push = wr_if.valid && wr_if.ready;
    pop = (count_q != '0) && (!out_vld_q || rd_if.ready);
    wr_ptr_d = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
    rd_ptr_d = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
    count_d = count_q + CW'(push) - CW'(pop);
    out_d = pop ? mem_q[rd_ptr_q] : out_q;
    out_vld_d = pop ? 1'b1 : (rd_if.ready ? 1'b0 : out_vld_q);
  end

  assign wr_if.ready = count_q != CW'(DEPTH);
  assign rd_if.valid = out_vld_q;
  assign rd_if.data = out_q;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      out_q <= '0;
      out_vld_q <= 1'b0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_d;
      out_q <= out_d;
      out_vld_q <= out_vld_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wr_ptr_q] <= wr_if.data;
    end
  end

  a_fifo_bound: assert property (@(posedge clk_in) disable iff (reset_in)
    count_q <= CW'(DEPTH))
    else $error("fifo count above depth");
  a_fifo_hold: assert property (@(posedge clk_in) disable iff (reset_in)
    rd_if.valid && !rd_if.ready |=> rd_if.valid && $stable(rd_if.data))
    else $error("fifo output dropped while stalled");
endmodule // t1rc_fifo
`default_nettype wire

/* File: verilog/t1rc_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
module t1rc_ctrl
  import t1rc_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [7:0] host_addr_in,
  input wire logic [7:0] host_wdata_in,
  input wire logic host_wr_in,
  input wire logic host_rd_in,
  output logic [7:0] host_rdata_out,
  input wire logic rx_line_pos_in,
  input wire logic rx_line_neg_in,
  input wire logic rx_bit_strobe_in,
  input wire logic tx_fmt_pos_in,
  input wire logic tx_fmt_neg_in,
  input wire logic tx_bit_strobe_in,
  output logic tx_line_pos_out,
  output logic tx_line_neg_out,
  output logic rx_framer_pos_out,
  output logic rx_framer_neg_out,
  output logic rx_framer_strobe_out,
  output logic rx_japan_crc_select_out,
  output logic far_loopback_enable_out,
  output logic line_if_reset_out,
  input wire logic [7:0] rx_chan_data_in,
  input wire logic [T1RC_CHAN_W-1:0] rx_chan_num_in,
  input wire logic rx_chan_valid_in,
  output logic rx_chan_ready_out,
  output logic [7:0] rx_channel_monitor_reg_out
);

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  // Host port registers
  logic crc_jp_q, crc_jp_d;
  logic [T1RC_CHAN_W-1:0] chan_sel_q, chan_sel_d;
  logic line_if_reset_bit_q, line_if_reset_bit_d;
  logic rlb_q, rlb_d;
  logic [7:0] rdata_q, rdata_d;
  logic wr_lrl, wr_rcm;
  logic [7:0] lrl_view, rcm_view;

  always_comb begin
    wr_lrl = host_wr_in && t1rc_addr_hit(host_addr_in, T1RC_LRL_ADDR);
    wr_rcm = host_wr_in && t1rc_addr_hit(host_addr_in, T1RC_RCM_ADDR);
    // Unassigned bits are not stored; host keeps them zero
    crc_jp_d = crc_jp_q;
    chan_sel_d = chan_sel_q;
    if (wr_rcm) begin
      crc_jp_d = host_wdata_in[T1RC_CRC_JP_BIT];
      chan_sel_d = host_wdata_in[T1RC_CHAN_MSB:T1RC_CHAN_LSB];
    end
    line_if_reset_bit_d = line_if_reset_bit_q;
    rlb_d = rlb_q;
    if (wr_lrl) begin
      line_if_reset_bit_d = host_wdata_in[T1RC_LINE_IF_RESET_BIT_BIT];
      rlb_d = host_wdata_in[T1RC_RLB_BIT];
    end
    lrl_view = T1RC_REG_RESET;
    lrl_view[T1RC_LINE_IF_RESET_BIT_BIT] = line_if_reset_bit_q;
    lrl_view[T1RC_RLB_BIT] = rlb_q;
    rcm_view = T1RC_REG_RESET;
    rcm_view[T1RC_CRC_JP_BIT] = crc_jp_q;
    rcm_view[T1RC_CHAN_MSB:T1RC_CHAN_LSB] = chan_sel_q;
    rdata_d = rdata_q;
    if (host_rd_in) begin
      if (t1rc_addr_hit(host_addr_in, T1RC_LRL_ADDR)) begin
        rdata_d = lrl_view;
      end else if (t1rc_addr_hit(host_addr_in, T1RC_RCM_ADDR)) begin
        rdata_d = rcm_view;
      end else begin
        rdata_d = T1RC_REG_RESET;
      end
    end
  end

  // Reset to zero anyway; software still rewrites everything
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      crc_jp_q <= 1'b0;
      chan_sel_q <= '0;
      line_if_reset_bit_q <= 1'b0;
      rlb_q <= 1'b0;
      rdata_q <= T1RC_REG_RESET;
    end else begin
      crc_jp_q <= crc_jp_d;
      chan_sel_q <= chan_sel_d;
      line_if_reset_bit_q <= line_if_reset_bit_d;
      rlb_q <= rlb_d;
      rdata_q <= rdata_d;
    end
  end

  assign host_rdata_out = rdata_q;
  assign rx_japan_crc_select_out = crc_jp_q;
  assign far_loopback_enable_out = rlb_q;

  // Line interface reset pulse
  t1rc_rst_state_t rst_state_q, rst_state_d;
  logic [T1RC_LINE_IF_RESET_BIT_CW-1:0] rst_cnt_q, rst_cnt_d;
  logic line_if_reset_bit_rise;

  always_comb begin
    // Writing one over one is no edge
    line_if_reset_bit_rise = wr_lrl && host_wdata_in[T1RC_LINE_IF_RESET_BIT_BIT] && !line_if_reset_bit_q;
    rst_state_d = rst_state_q;
    rst_cnt_d = rst_cnt_q;
    case (rst_state_q)
      T1RC_RST_IDLE: begin
        if (line_if_reset_bit_rise) begin
          rst_state_d = T1RC_RST_PULSE;
          rst_cnt_d = T1RC_LINE_IF_RESET_BIT_CW'(T1RC_LINE_IF_RESET_BIT_CYCLES - 1);
        end
      end
      T1RC_RST_PULSE: begin
        // Edges during a pulse are absorbed to keep its length fixed
        if (rst_cnt_q == '0) begin
          rst_state_d = T1RC_RST_IDLE;
        end else begin
          rst_cnt_d = rst_cnt_q - 1'b1;
        end
      end
      default: begin
        rst_state_d = T1RC_RST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rst_state_q <= T1RC_RST_IDLE;
      rst_cnt_q <= '0;
    end else begin
      rst_state_q <= rst_state_d;
      rst_cnt_q <= rst_cnt_d;
    end
  end

  assign line_if_reset_out = rst_state_q == T1RC_RST_PULSE;

  // Line data paths
  logic tx_pos_q, tx_pos_d, tx_neg_q, tx_neg_d;
  logic fr_pos_q, fr_pos_d, fr_neg_q, fr_neg_d;
  logic fr_stb_q, fr_stb_d;

  always_comb begin
    tx_pos_d = tx_pos_q;
    tx_neg_d = tx_neg_q;
    if (rlb_q) begin
      // Recovered clock tick times the returned bits
      if (rx_bit_strobe_in) begin
        tx_pos_d = rx_line_pos_in;
        tx_neg_d = rx_line_neg_in;
      end
    end else if (tx_bit_strobe_in) begin
      tx_pos_d = tx_fmt_pos_in;
      tx_neg_d = tx_fmt_neg_in;
    end
    // Framer feed does not look at the loopback bit
    fr_pos_d = rx_bit_strobe_in ? rx_line_pos_in : fr_pos_q;
    fr_neg_d = rx_bit_strobe_in ? rx_line_neg_in : fr_neg_q;
    fr_stb_d = rx_bit_strobe_in;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tx_pos_q <= 1'b0;
      tx_neg_q <= 1'b0;
      fr_pos_q <= 1'b0;
      fr_neg_q <= 1'b0;
      fr_stb_q <= 1'b0;
    end else begin
      tx_pos_q <= tx_pos_d;
      tx_neg_q <= tx_neg_d;
      fr_pos_q <= fr_pos_d;
      fr_neg_q <= fr_neg_d;
      fr_stb_q <= fr_stb_d;
    end
  end

  assign tx_line_pos_out = tx_pos_q;
  assign tx_line_neg_out = tx_neg_q;
  assign rx_framer_pos_out = fr_pos_q;
  assign rx_framer_neg_out = fr_neg_q;
  assign rx_framer_strobe_out = fr_stb_q;

  // Receive channel monitor, buffered behind a FIFO
  t1rc_stream_if #(.WIDTH(T1RC_MON_WIDTH)) mon_wr_if ();
  t1rc_stream_if #(.WIDTH(T1RC_MON_WIDTH)) mon_rd_if ();

  assign mon_wr_if.valid = rx_chan_valid_in;
  assign mon_wr_if.data = {rx_chan_num_in, rx_chan_data_in};
  assign rx_chan_ready_out = mon_wr_if.ready;

  t1rc_fifo #(
    .WIDTH(T1RC_MON_WIDTH),
    .DEPTH(T1RC_FIFO_DEPTH)
  ) u_mon_fifo (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .wr_if(mon_wr_if),
    .rd_if(mon_rd_if)
  );

  logic [7:0] mon_q, mon_d;
  logic mon_take, mon_match;

  // Draining stops during the line reset so the FIFO soaks up bytes
  assign mon_rd_if.ready = !line_if_reset_out;

  always_comb begin
    mon_take = mon_rd_if.valid && mon_rd_if.ready;
    mon_match = mon_rd_if.data[T1RC_MON_WIDTH-1:T1RC_BYTE_W] == chan_sel_q;
    mon_d = (mon_take && mon_match) ?
            mon_rd_if.data[T1RC_BYTE_W-1:0] : mon_q;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      mon_q <= '0;
    end else begin
      mon_q <= mon_d;
    end
  end

  assign rx_channel_monitor_reg_out = mon_q;

  // Checks
  logic [T1RC_LINE_IF_RESET_BIT_CW:0] pulse_len_q;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pulse_len_q <= '0;
    end else if (line_if_reset_out) begin
      pulse_len_q <= pulse_len_q + 1'b1;
    end else begin
      pulse_len_q <= '0;
    end
  end

  sequence s_idle_rise;
    rst_state_q == T1RC_RST_IDLE && line_if_reset_bit_rise;
  endsequence

  sequence s_pulse_start;
    line_if_reset_out [*8];
  endsequence

  a_line_if_reset_bit_starts: assert property (
    s_idle_rise |=> s_pulse_start)
    else $error("reset bit edge gave no pulse");

  a_line_if_reset_bit_no_rearm: assert property (
    !line_if_reset_out && wr_lrl && line_if_reset_bit_q |=> !line_if_reset_out)
    else $error("rewriting one restarted the reset");

  a_pulse_length: assert property (
    $fell(line_if_reset_out) |->
      pulse_len_q == (T1RC_LINE_IF_RESET_BIT_CW + 1)'(T1RC_LINE_IF_RESET_BIT_CYCLES))
    else $error("line reset pulse has wrong length");

  a_crc_select: assert property (
    wr_rcm |=> rx_japan_crc_select_out == $past(host_wdata_in[7]))
    else $error("CRC6 select not taken from write");

  a_loop_route: assert property (
    rlb_q && rx_bit_strobe_in |=>
      tx_line_pos_out == $past(rx_line_pos_in) &&
      tx_line_neg_out == $past(rx_line_neg_in))
    else $error("receive pair not looped to line");

  a_fmt_blocked: assert property (
    rlb_q && !rx_bit_strobe_in |=>
      $stable(tx_line_pos_out) && $stable(tx_line_neg_out))
    else $error("transmit line moved without recovered tick");

  a_normal_path: assert property (
    !rlb_q && tx_bit_strobe_in |=>
      tx_line_pos_out == $past(tx_fmt_pos_in) &&
      tx_line_neg_out == $past(tx_fmt_neg_in))
    else $error("formatter data missing on line");

  a_framer_kept: assert property (
    rx_bit_strobe_in |=> rx_framer_strobe_out &&
      rx_framer_pos_out == $past(rx_line_pos_in))
    else $error("framer feed lost");

  a_mon_capture: assert property (
    mon_take && mon_match |=>
      rx_channel_monitor_reg_out == $past(mon_rd_if.data[7:0]))
    else $error("selected channel not captured");

  a_mon_other: assert property (
    mon_take && !mon_match |=> $stable(rx_channel_monitor_reg_out))
    else $error("unselected channel captured");

  a_read_back: assert property (
    host_rd_in && t1rc_addr_hit(host_addr_in, T1RC_LRL_ADDR) |=>
      host_rdata_out[6] == $past(rlb_q) && host_rdata_out[5:0] == '0)
    else $error("loopback register read wrong");
endmodule // t1rc_ctrl
`default_nettype wire

/* File: sim/t1rc_line_model.sv */
`timescale 1ns/100ps
`default_nettype none
module t1rc_line_model (
  input wire logic clk_in,
  input wire logic reset_in,
  output logic rx_pos_out,
  output logic rx_neg_out,
  output logic rx_stb_out,
  output logic tx_pos_out,
  output logic tx_neg_out,
  output logic tx_stb_out
);
  logic [7:0] cnt_q = 8'h00;
  always @(negedge clk_in) begin
    if (reset_in) cnt_q <= 8'h00;
    else cnt_q <= cnt_q + 8'h01;
  end
  // Recovered clock ticks every other cycle only
  assign rx_stb_out = cnt_q[0];
  // Rails never both high; data moves between ticks too
  assign rx_pos_out = cnt_q[1] ^ cnt_q[3];
  assign rx_neg_out = ~rx_pos_out & cnt_q[2];
  assign tx_stb_out = (cnt_q % 8'h03) == 8'h00;
  assign tx_pos_out = cnt_q[2];
  assign tx_neg_out = ~cnt_q[2] & cnt_q[1];
endmodule // t1rc_line_model
`default_nettype wire

/* File: sim/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import t1rc_pkg::*;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] host_addr = 8'h00;
  logic [7:0] host_wdata = 8'h00;
  logic host_wr = 1'b0;
  logic host_rd = 1'b0;
  logic [7:0] chan_data = 8'h00;
  logic [T1RC_CHAN_W-1:0] chan_num = '0;
  logic chan_valid = 1'b0;
  logic [7:0] host_rdata_out, mon_out;
  logic rx_pos, rx_neg, rx_stb, tx_pos, tx_neg, tx_stb;
  logic tx_line_pos_out, tx_line_neg_out, fr_pos, fr_neg, fr_stb;
  logic crc_out, rlb_out, lrst_out, ready_out;
  logic [7:0] d;
  logic crc_e, rlb_e;
  int err_total = 0;
  int tests_run = 0;
  int n;
  localparam logic [23:0] ROWS [6] = '{{8'h1e, 8'h9f, 8'h9f},
    {8'h1e, 8'h0a, 8'h0a}, {8'h1e, 8'h15, 8'h15}, {8'h0a, 8'h40, 8'h40},
    {8'h0a, 8'h00, 8'h00}, {8'h33, 8'hff, 8'h00}};

  t1rc_line_model line (.clk_in(clk_in), .reset_in(reset_in),
    .rx_pos_out(rx_pos), .rx_neg_out(rx_neg), .rx_stb_out(rx_stb),
    .tx_pos_out(tx_pos), .tx_neg_out(tx_neg), .tx_stb_out(tx_stb));

  t1rc_ctrl dut (.clk_in(clk_in), .reset_in(reset_in),
    .host_addr_in(host_addr), .host_wdata_in(host_wdata),
    .host_wr_in(host_wr), .host_rd_in(host_rd),
    .host_rdata_out(host_rdata_out), .rx_line_pos_in(rx_pos),
    .rx_line_neg_in(rx_neg), .rx_bit_strobe_in(rx_stb),
    .tx_fmt_pos_in(tx_pos), .tx_fmt_neg_in(tx_neg),
    .tx_bit_strobe_in(tx_stb), .tx_line_pos_out(tx_line_pos_out),
    .tx_line_neg_out(tx_line_neg_out), .rx_framer_pos_out(fr_pos),
    .rx_framer_neg_out(fr_neg), .rx_framer_strobe_out(fr_stb),
    .rx_japan_crc_select_out(crc_out), .far_loopback_enable_out(rlb_out),
    .line_if_reset_out(lrst_out), .rx_chan_data_in(chan_data),
    .rx_chan_num_in(chan_num), .rx_chan_valid_in(chan_valid),
    .rx_chan_ready_out(ready_out), .rx_channel_monitor_reg_out(mon_out));

  initial begin
    forever #5 clk_in = ~clk_in;
  end

  task automatic chk1(input logic got, input logic exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
                      input string msg);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask

  // Idle cycle after each access so a strobe never rises where it fell
  task automatic host_write(input logic [7:0] a, input logic [7:0] v);
    host_addr = a;
    host_wdata = v;
    host_wr = 1'b1;
    @(negedge clk_in);
    host_wr = 1'b0;
    @(negedge clk_in);
  endtask

  task automatic host_read(input logic [7:0] a, output logic [7:0] v);
    host_addr = a;
    host_rd = 1'b1;
    @(negedge clk_in);
    host_rd = 1'b0;
    v = host_rdata_out;
    @(negedge clk_in);
  endtask

  // Holds the word until ready is seen before an edge
  task automatic push(input logic [7:0] v, input logic [T1RC_CHAN_W-1:0] c);
    int k;
    chan_data = v;
    chan_num = c;
    chan_valid = 1'b1;
    k = 0;
    while (ready_out !== 1'b1 && k < 50) begin
      @(negedge clk_in);
      k++;
    end
    if (k >= 50) begin
      err_total++;
      $display("CHECK FAILED t=%0t push never accepted", $time);
    end
    @(negedge clk_in);
  endtask

  // Model values read here are those the last rising edge sampled
  task automatic line_run(input logic lb);
    logic ep, en, ok, fs;
    ok = 1'b0;
    repeat (40) begin
      @(negedge clk_in);
      chk1(fr_stb, rx_stb, "framer strobe");
      if (rx_stb) begin
        chk1(fr_pos, rx_pos, "framer pos");
        chk1(fr_neg, rx_neg, "framer neg");
      end
      fs = lb ? rx_stb : tx_stb;
      if (fs) begin
        ep = lb ? rx_pos : tx_pos;
        en = lb ? rx_neg : tx_neg;
        ok = 1'b1;
      end
      if (ok) begin
        chk1(tx_line_pos_out, ep, "tx pos");
        chk1(tx_line_neg_out, en, "tx neg");
      end
    end
  endtask

  task automatic final_report;
    $display("Checks run %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #200000;
    err_total++;
    final_report();
  end

  initial begin
    repeat (16) @(negedge clk_in);
    reset_in = 1'b0;
    chk1(lrst_out, 1'b0, "reset pulse idle");
    chk1(ready_out, 1'b1, "ready after reset");
    host_read(T1RC_LRL_ADDR, d);
    chk8(d, T1RC_REG_RESET, "reset value lrl");
    host_read(T1RC_RCM_ADDR, d);
    chk8(d, T1RC_REG_RESET, "reset value rcm");
    crc_e = 1'b0;
    rlb_e = 1'b0;
    // Host configures every register, unassigned bits kept zero
    foreach (ROWS[i]) begin
      host_write(ROWS[i][23:16], ROWS[i][15:8]);
      host_read(ROWS[i][23:16], d);
      chk8(d, ROWS[i][7:0], "readback");
      if (ROWS[i][23:16] == T1RC_RCM_ADDR) crc_e = ROWS[i][7];
      if (ROWS[i][23:16] == T1RC_LRL_ADDR) rlb_e = ROWS[i][6];
      chk1(crc_out, crc_e, "crc select");
      chk1(rlb_out, rlb_e, "loopback enable");
    end
    host_write(T1RC_LRL_ADDR, 8'h40);
    line_run(1'b1);
    host_write(T1RC_LRL_ADDR, 8'h00);
    line_run(1'b0);
    // Fill the buffer while the reset pulse stalls its drain
    host_write(T1RC_RCM_ADDR, 8'h03);
    host_write(T1RC_LRL_ADDR, 8'h80);
    chk1(lrst_out, 1'b1, "pulse start");
    // One word parks in the output register, so 17 words fill it
    for (int i = 0; i < 17; i++) begin
      push(8'(i), i[0] ? 5'h03 : 5'h04);
    end
    chan_valid = 1'b0;
    chk1(ready_out, 1'b0, "buffer full");
    chk8(mon_out, 8'h00, "monitor stalled");
    n = 0;
    while (lrst_out === 1'b1 && n < 300) begin
      @(negedge clk_in);
      n++;
    end
    if (n >= 300) begin
      err_total++;
      $display("CHECK FAILED t=%0t reset pulse never ended", $time);
    end
    repeat (60) @(negedge clk_in);
    chk8(mon_out, 8'h0f, "monitor last match");
    chk1(ready_out, 1'b1, "buffer drained");
    host_write(T1RC_LRL_ADDR, 8'h80);
    n = 0;
    repeat (20) begin
      n += int'(lrst_out === 1'b1);
      @(negedge clk_in);
    end
    chk8(8'(n), 8'h00, "no pulse on 1 to 1");
    host_write(T1RC_LRL_ADDR, 8'h00);
    host_write(T1RC_LRL_ADDR, 8'h80);
    // First high cycle passes inside the write task
    n = 1;
    while (lrst_out === 1'b1 && n < 300) begin
      n++;
      @(negedge clk_in);
    end
    chk8(8'(n), 8'(T1RC_LINE_IF_RESET_BIT_CYCLES), "pulse length");
    final_report();
  end
endmodule // testbench
`default_nettype wire
